// >>> rtl/tplw_params.svh
`ifndef TPLW_PARAMS_SVH
`define TPLW_PARAMS_SVH

// Partition geometry: 8 partitions of 16 lines, 128-bit lines of four 32-bit lanes
`define TPLW_NPART 8
`define TPLW_LINES 16
`define TPLW_DEPTH 128
`define TPLW_OCC_FULL 5'h10

// Access width codes held in the control register
`define TPLW_MODE_32 2'h0
`define TPLW_MODE_64 2'h1
`define TPLW_MODE_128 2'h2

// Register byte offsets
`define TPLW_OFF_CTRL 8'h00
`define TPLW_OFF_POP 8'h04
`define TPLW_OFF_RDSEL 8'h08
`define TPLW_OFF_STATUS 8'h0c
`define TPLW_OFF_DATA0 8'h10
`define TPLW_OFF_DATA1 8'h14
`define TPLW_OFF_DATA2 8'h18
`define TPLW_OFF_DATA3 8'h1c
`define TPLW_OFF_SIDE 8'h20

// Control register fields and reset values
`define TPLW_CTRL_MODE_LSB 0
`define TPLW_CTRL_FILL_LSB 8
`define TPLW_MODE_RST 2'h0
`define TPLW_FILL_RST 4'hc

`endif

// >>> rtl/tplw_pkg.sv
package tplw_pkg;

    // Read port registers of the line memory
    typedef struct packed {
        logic [127:0] data;
        logic [15:0] mask;
        logic [7:0] tag;
        logic sop;
        logic eop;
        logic err;
    } tplw_mem_s;

    // Whole state of the writer
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] fill;
        logic [2:0] sel;
        logic [7:0][4:0] wr_ptr;
        logic [7:0][4:0] rd_ptr;
        logic [7:0][1:0] pos;
        logic part_full;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tplw_top_s;

endpackage

// >>> rtl/tplw_line_mem.sv
`timescale 1ns/1ps
`include "tplw_params.svh"

module tplw_line_mem import tplw_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [6:0] wr_line,
    input wire logic [3:0] lane_we,
    input wire logic [127:0] lane_data,
    input wire logic [3:0] mask_we,
    input wire logic [15:0] mask_data,
    input wire logic tag_we,
    input wire logic [7:0] tag_data,
    input wire logic sop_we,
    input wire logic sop_data,
    input wire logic end_we,
    input wire logic eop_data,
    input wire logic err_data,
    input wire logic [6:0] rd_line,
    output tplw_mem_s rd_q
);
    logic [127:0] rd_data;
    logic [15:0] rd_mask;
    logic [7:0] tag_mem [`TPLW_DEPTH];
    logic [2:0] flag_mem [`TPLW_DEPTH];
    tplw_mem_s st_r;
    tplw_mem_s st_nxt;

    // Lanes are written in place, so a partly built line needs no staging buffer
    // Each lane owns its arrays, so no memory word has two writing processes
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            logic [31:0] data_mem [`TPLW_DEPTH];
            logic [3:0] mask_mem [`TPLW_DEPTH];
            always_ff @(posedge mclk) begin
                if (lane_we[g]) begin
                    data_mem[wr_line] <= lane_data[g*32 +: 32];
                end
                if (mask_we[g]) begin
                    mask_mem[wr_line] <= mask_data[g*4 +: 4];
                end
            end
            assign rd_data[g*32 +: 32] = data_mem[rd_line];
            assign rd_mask[g*4 +: 4] = mask_mem[rd_line];
        end
    endgenerate

    // Sideband: tag follows every write, markers only where they belong
    always_ff @(posedge mclk) begin
        if (tag_we) begin
            tag_mem[wr_line] <= tag_data;
        end
        if (sop_we) begin
            flag_mem[wr_line][2] <= sop_data;
        end
        if (end_we) begin
            flag_mem[wr_line][1:0] <= {eop_data, err_data};
        end
    end

    // Registered read of the selected line
    always_comb begin
        st_nxt = st_r;
        st_nxt.data = rd_data;
        st_nxt.mask = rd_mask;
        st_nxt.tag = tag_mem[rd_line];
        st_nxt.sop = flag_mem[rd_line][2];
        st_nxt.eop = flag_mem[rd_line][1];
        st_nxt.err = flag_mem[rd_line][0];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_q = st_r;
endmodule

// >>> rtl/tplw_writer.sv
// Overview of operation
// (R1) Writer drives partition address with write strobe; strobe qualifies all inputs.
// (R2) Writer asserts start marker on the first write of each packet.
// (R3) Channel tag of a write is stored as the line's control word port field.
// (R4) Each mask bit validates one byte; 32-bit mask 0xC means upper two bytes.
// (R5) In 32-bit mode the line pointer advances after every fourth write.
// (R6) End marker closes the packet and advances the pointer, partial line or not.
// (R7) Writer holds the channel tag, at least on the write completing a line.
// (R8) Full lines may switch partition next cycle; writes accepted at full throughput.
// (R9) Each partition keeps its own write pointer and resumes at its next line.
// (R10) Packets are at least one 16-byte line; one start and end per line.
// (R11) Writer puts only one channel's data into any single line.
// (R12) Packet start always lands in the first byte of a line.
// (R13) End marker accepted on any of the four 32-bit writes of a line.
// (R14) In 64-bit mode the mask has eight bits; 0xFE marks seven valid.
// (R15) In 64-bit mode writer presents the tag at least on each second write.
// (R16) In 64-bit mode the line pointer advances after every second write.
// (R17) In 128-bit mode each qualified write fills a complete line.
// (R18) Writer drives the error indicator only together with the end marker.
// (R19) A write with no mask bit set is discarded and moves no pointer.
// (R20) Full flag rises when the addressed partition's occupancy passes the fill level.
// (R21) Every write interface signal is sampled on the rising edge of mclk.
// (R22) Cycles without write strobe change no memory, pointer or packet state.
// (R23) Byte position within the current line is kept separately per partition.
`timescale 1ns/1ps
`include "tplw_params.svh"

module tplw_writer import tplw_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] wr_addr,
    input wire logic wr_strobe,
    input wire logic [127:0] wr_data,
    input wire logic [15:0] byte_valid_mask,
    input wire logic [7:0] channel_tag,
    input wire logic wr_sop,
    input wire logic wr_eop,
    input wire logic wr_err,
    input wire logic line_term,
    output logic part_full
);
    tplw_top_s st_r;
    tplw_top_s st_nxt;
    tplw_mem_s rd_q;
    logic [7:0][4:0] occ;
    logic [4:0] occ_addr;
    logic [4:0] cur_wp;
    logic [1:0] cur_pos;
    logic any_valid;
    logic accept;
    logic line_done;
    logic over_fill;
    logic [3:0] lane_we;
    logic [127:0] lane_data;
    logic [3:0] mask_we;
    logic [15:0] mask_data;
    logic [6:0] wr_line;
    logic [6:0] rd_line;
    logic apb_setup;
    logic apb_access;

    // Occupancy in whole lines; the extra pointer bit tells full from empty
    genvar g;
    generate
        for (g = 0; g < `TPLW_NPART; g = g + 1) begin : g_occ
            assign occ[g] = st_r.wr_ptr[g] - st_r.rd_ptr[g];
        end
    endgenerate

    // Addressed partition view; every input is taken at the mclk rising edge
    // (R21) same-edge sampling
    assign occ_addr = occ[wr_addr];
    assign cur_wp = st_r.wr_ptr[wr_addr];
    assign cur_pos = st_r.pos[wr_addr];
    assign wr_line = {wr_addr, cur_wp[3:0]};
    assign rd_line = {st_r.sel, st_r.rd_ptr[st_r.sel][3:0]};
    assign over_fill = occ_addr > {1'b0, st_r.fill};
    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable & st_r.pready;

    // Only the mask bits of the active width count as valid bytes
    // (R4) 32-bit mask width
    // (R14) 64-bit mask width
    always_comb begin
        case (st_r.mode)
            `TPLW_MODE_32: begin
                any_valid = |byte_valid_mask[3:0];
                line_done = cur_pos == 2'h3;
            end
            `TPLW_MODE_64: begin
                any_valid = |byte_valid_mask[7:0];
                line_done = cur_pos == 2'h1;
            end
            default: begin
                any_valid = |byte_valid_mask;
                line_done = 1'b1;
            end
        endcase
    end

    // Strobe qualifies the cycle; empty masks and full partitions are dropped
    // (R1) strobe qualifies inputs
    // (R19) empty mask dropped
    // (R22) idle cycles inert
    assign accept = wr_strobe & any_valid & (occ_addr != `TPLW_OCC_FULL);

    // Steer the narrow write into its lane of the line
    // (R17) 128-bit full line
    always_comb begin
        case (st_r.mode)
            `TPLW_MODE_32: begin
                lane_data = {4{wr_data[31:0]}};
                lane_we = 4'h1 << cur_pos;
                mask_data = {12'h000, byte_valid_mask[3:0]} << {cur_pos, 2'h0};
            end
            `TPLW_MODE_64: begin
                lane_data = {2{wr_data[63:0]}};
                lane_we = 4'h3 << {cur_pos[0], 1'h0};
                mask_data = {8'h00, byte_valid_mask[7:0]} << {cur_pos[0], 3'h0};
            end
            default: begin
                lane_data = wr_data;
                lane_we = 4'hf;
                mask_data = byte_valid_mask;
            end
        endcase
        if (!accept) begin
            lane_we = 4'h0;
        end
        // First write of a line clears stale masks of lanes a short line never reaches
        mask_we = (accept && cur_pos == 2'h0) ? 4'hf : lane_we;
    end

    // (R3) tag kept as port field
    tplw_line_mem u_mem (
        .mclk(mclk),
        .rst(rst),
        .wr_line(wr_line),
        .lane_we(lane_we),
        .lane_data(lane_data),
        .mask_we(mask_we),
        .mask_data(mask_data),
        .tag_we(accept),
        .tag_data(channel_tag),
        .sop_we(accept && cur_pos == 2'h0),
        .sop_data(wr_sop),
        .end_we(accept && (cur_pos == 2'h0 || wr_eop)),
        .eop_data(wr_eop),
        .err_data(wr_err),
        .rd_line(rd_line),
        .rd_q(rd_q)
    );

    // Next state: write pointers, APB slave and full flag
    always_comb begin
        st_nxt = st_r;
        st_nxt.pready = apb_setup;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata = 32'h0000_0000;

        // Line pointer steps on a full line, an end marker or a line termination
        // (R5) fourth write closes line
        // (R6) end marker advances
        // (R13) end on any word
        // (R16) second write closes line
        // (R9) per-partition pointer
        // (R23) per-partition position
        // (R8) no stall between partitions
        if (accept) begin
            if (line_done || wr_eop || line_term) begin
                st_nxt.wr_ptr[wr_addr] = cur_wp + 5'h01;
                st_nxt.pos[wr_addr] = 2'h0;
            end else begin
                st_nxt.pos[wr_addr] = cur_pos + 2'h1;
            end
        end

        // Flag follows the partition addressed in the previous cycle
        // (R20) fill level flag
        st_nxt.part_full = over_fill;

        // Read data is prepared during setup so access needs no wait state
        if (apb_setup) begin
            case (paddr)
                `TPLW_OFF_CTRL: begin
                    st_nxt.prdata[`TPLW_CTRL_MODE_LSB +: 2] = st_r.mode;
                    st_nxt.prdata[`TPLW_CTRL_FILL_LSB +: 4] = st_r.fill;
                end
                `TPLW_OFF_POP: begin
                    st_nxt.prdata = 32'h0000_0000;
                end
                `TPLW_OFF_RDSEL: begin
                    st_nxt.prdata[2:0] = st_r.sel;
                end
                `TPLW_OFF_STATUS: begin
                    st_nxt.prdata[4:0] = occ[st_r.sel];
                    st_nxt.prdata[12:8] = st_r.wr_ptr[st_r.sel];
                    st_nxt.prdata[17:16] = st_r.pos[st_r.sel];
                    st_nxt.prdata[24] = occ[st_r.sel] > {1'b0, st_r.fill};
                end
                `TPLW_OFF_DATA0: begin
                    st_nxt.prdata = rd_q.data[31:0];
                end
                `TPLW_OFF_DATA1: begin
                    st_nxt.prdata = rd_q.data[63:32];
                end
                `TPLW_OFF_DATA2: begin
                    st_nxt.prdata = rd_q.data[95:64];
                end
                `TPLW_OFF_DATA3: begin
                    st_nxt.prdata = rd_q.data[127:96];
                end
                `TPLW_OFF_SIDE: begin
                    st_nxt.prdata = {5'h00, rd_q.err, rd_q.eop, rd_q.sop, rd_q.tag, rd_q.mask};
                end
                default: begin
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // Writes land only at the access edge; mode changes mid-line are unsafe
        if (apb_access && pwrite) begin
            case (paddr)
                `TPLW_OFF_CTRL: begin
                    st_nxt.mode = pwdata[`TPLW_CTRL_MODE_LSB +: 2];
                    st_nxt.fill = pwdata[`TPLW_CTRL_FILL_LSB +: 4];
                end
                `TPLW_OFF_POP: begin
                    if (occ[pwdata[2:0]] != 5'h00) begin
                        st_nxt.rd_ptr[pwdata[2:0]] = st_r.rd_ptr[pwdata[2:0]] + 5'h01;
                    end
                end
                `TPLW_OFF_RDSEL: begin
                    st_nxt.sel = pwdata[2:0];
                end
                default: begin
                    st_nxt.sel = st_r.sel;
                end
            endcase
        end
    end

    // Single state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
            st_r.mode <= `TPLW_MODE_RST;
            st_r.fill <= `TPLW_FILL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign part_full = st_r.part_full;

    // Idle cycles leave pointers and positions alone
    chk_idle_no_move: assert property (@(posedge mclk) disable iff (rst) // R22
        !wr_strobe |=> $stable(st_r.wr_ptr) && $stable(st_r.pos))
        else $error("Pointer moved without write strobe");

    // Empty mask must not reach the memory
    chk_zero_mask_drop: assert property (@(posedge mclk) disable iff (rst) // R19
        (wr_strobe && !any_valid) |-> (lane_we == 4'h0) ##1 $stable(st_r.wr_ptr))
        else $error("Write with empty mask was stored");

    // End marker advances the addressed pointer by one line
    chk_eop_advance: assert property (@(posedge mclk) disable iff (rst) // R6
        (accept && wr_eop) |=>
        st_r.wr_ptr[$past(wr_addr)] == $past(cur_wp) + 5'h01 && st_r.pos[$past(wr_addr)] == 2'h0)
        else $error("End marker did not close the line");

    // Fourth 32-bit write closes a line
    chk_four_writes: assert property (@(posedge mclk) disable iff (rst) // R5
        (accept && st_r.mode == `TPLW_MODE_32 && cur_pos == 2'h3) |=>
        st_r.wr_ptr[$past(wr_addr)] == $past(cur_wp) + 5'h01)
        else $error("32-bit line not closed after four writes");

    // Mid-line writes keep the pointer and step the position
    chk_mid_line_hold: assert property (@(posedge mclk) disable iff (rst) // R13
        (accept && !line_done && !wr_eop && !line_term) |=>
        st_r.wr_ptr[$past(wr_addr)] == $past(cur_wp) &&
        st_r.pos[$past(wr_addr)] == $past(cur_pos) + 2'h1)
        else $error("Pointer moved before the line was complete");

    // Second 64-bit write closes a line
    chk_two_writes: assert property (@(posedge mclk) disable iff (rst) // R16
        (accept && st_r.mode == `TPLW_MODE_64 && cur_pos == 2'h1) |=>
        st_r.wr_ptr[$past(wr_addr)] == $past(cur_wp) + 5'h01)
        else $error("64-bit line not closed after two writes");

    // A 128-bit write fills every lane and closes the line
    chk_full_line: assert property (@(posedge mclk) disable iff (rst) // R17
        (accept && st_r.mode == `TPLW_MODE_128) |-> (lane_we == 4'hf) ##1
        (st_r.wr_ptr[$past(wr_addr)] == $past(cur_wp) + 5'h01))
        else $error("128-bit write did not fill a line");

    // Full flag reflects last cycle's occupancy against the fill level
    chk_full_flag: assert property (@(posedge mclk) disable iff (rst) // R20
        1'b1 |=> part_full == $past(over_fill))
        else $error("Full flag does not match occupancy");

    // Setup phase is answered in the following cycle
    chk_apb_ready: assert property (@(posedge mclk) disable iff (rst)
        apb_setup |=> pready ##1 !pready)
        else $error("APB answer not one cycle after setup");

    // A write leaves the neighbouring partition's pointer and position alone
    chk_other_part: assert property (@(posedge mclk) disable iff (rst) // R9
        accept |=> st_r.wr_ptr[$past(wr_addr) + 3'h1] == $past(st_r.wr_ptr[wr_addr + 3'h1]) &&
        st_r.pos[$past(wr_addr) + 3'h1] == $past(st_r.pos[wr_addr + 3'h1]))
        else $error("Write moved another partition");

    // A 32-bit mask lands on the byte lanes being written
    chk_mask_lane32: assert property (@(posedge mclk) disable iff (rst) // R4
        (accept && st_r.mode == `TPLW_MODE_32) |->
        mask_data[{cur_pos, 2'h0} +: 4] == byte_valid_mask[3:0] && lane_we == (4'h1 << cur_pos))
        else $error("32-bit mask not on its lane");

    // A 64-bit mask lands on the half line being written
    chk_mask_lane64: assert property (@(posedge mclk) disable iff (rst) // R14
        (accept && st_r.mode == `TPLW_MODE_64) |->
        mask_data[{cur_pos[0], 3'h0} +: 8] == byte_valid_mask[7:0])
        else $error("64-bit mask not on its half line");

    // Line termination closes a partly built line like an end marker
    chk_term_close: assert property (@(posedge mclk) disable iff (rst)
        (accept && line_term) |=>
        st_r.wr_ptr[$past(wr_addr)] == $past(cur_wp) + 5'h01 && st_r.pos[$past(wr_addr)] == 2'h0)
        else $error("Line termination did not close the line");

    // A partition holding all its lines takes nothing more
    chk_full_refuse: assert property (@(posedge mclk) disable iff (rst)
        (wr_strobe && occ_addr == `TPLW_OCC_FULL) |-> !accept ##1 $stable(st_r.wr_ptr))
        else $error("Write accepted into a full partition");
endmodule

// >>> dv/tplw_fabric_model.sv
`timescale 1ns/1ps

module tplw_fabric_model (
    input wire logic mclk,
    output logic [2:0] wr_addr,
    output logic wr_strobe,
    output logic [127:0] wr_data,
    output logic [15:0] byte_valid_mask,
    output logic [7:0] channel_tag,
    output logic wr_sop,
    output logic wr_eop,
    output logic wr_err,
    output logic line_term
);
    // Quiet interface at time zero
    initial begin
        wr_addr = 3'h0;
        wr_strobe = 1'b0;
        wr_data = 128'h0;
        byte_valid_mask = 16'h0;
        channel_tag = 8'h00;
        wr_sop = 1'b0;
        wr_eop = 1'b0;
        wr_err = 1'b0;
        line_term = 1'b0;
    end

    task automatic wr(input logic [2:0] p, input logic [127:0] d, input logic [15:0] m,
                      input logic [7:0] t, input logic s, input logic e, input logic x);
        @(posedge mclk);
        wr_strobe <= 1'b1;
        wr_addr <= p;
        wr_data <= d;
        byte_valid_mask <= m;
        channel_tag <= t;
        wr_sop <= s;
        wr_eop <= e;
        wr_err <= x & e;
    endtask

    // Unqualified lines carry garbage, so a design that ignores the strobe is caught
    task automatic idle();
        @(posedge mclk);
        wr_strobe <= 1'b0;
        wr_addr <= ~wr_addr;
        wr_data <= ~wr_data;
        byte_valid_mask <= ~byte_valid_mask;
        channel_tag <= ~channel_tag;
        wr_sop <= ~wr_sop;
        wr_eop <= ~wr_eop;
        wr_err <= ~wr_err;
    endtask

    // One 32-bit write that closes its line early without an end marker
    task automatic term(input logic [2:0] p, input logic [31:0] d, input logic [7:0] t);
        @(posedge mclk);
        wr_strobe <= 1'b1;
        wr_addr <= p;
        wr_data <= {96'h0, d};
        byte_valid_mask <= 16'h000f;
        channel_tag <= t;
        wr_sop <= 1'b0;
        wr_eop <= 1'b0;
        wr_err <= 1'b0;
        line_term <= 1'b1;
        @(posedge mclk);
        wr_strobe <= 1'b0;
        line_term <= 1'b0;
    endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "tplw_params.svh"

module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] wr_addr;
    logic wr_strobe;
    logic [127:0] wr_data;
    logic [15:0] byte_valid_mask;
    logic [7:0] channel_tag;
    logic wr_sop;
    logic wr_eop;
    logic wr_err;
    logic line_term;
    logic part_full;
    int miscompares = 0;
    int checks_done = 0;
    int occ;
    logic [31:0] seed = 32'h0f034296;
    logic [31:0] q;
    logic e;
    logic [127:0] d;
    logic [127:0] d3;
    logic [127:0] d4;
    logic [127:0] d5;
    logic [127:0] d7;
    localparam logic [31:0] ALL_M = 32'hffffffff;

    // 25 MHz clock
    always #20 mclk = ~mclk;

    tplw_writer u_tplw_writer (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .wr_addr, .wr_strobe, .wr_data, .byte_valid_mask,
        .channel_tag, .wr_sop, .wr_eop, .wr_err, .line_term, .part_full);

    tplw_fabric_model u_tplw_fabric_model (.mclk, .wr_addr, .wr_strobe, .wr_data,
        .byte_valid_mask, .channel_tag, .wr_sop, .wr_eop, .wr_err, .line_term);

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Sideband word: f holds err, eop, sop
    function automatic logic [31:0] side_exp(input logic [15:0] m, input logic [7:0] t,
                                             input logic [2:0] f);
        return {5'h0, f, t, m};
    endfunction

    function automatic logic [31:0] stat_exp(input int o, input logic [4:0] w, input logic [1:0] s);
        return {7'h0, o > `TPLW_FILL_RST, 6'h0, s, 3'h0, w, 3'h0, o[4:0]};
    endfunction

    task automatic rnd128();
        repeat (4) begin
            seed = lfsr_next(seed);
            d = {d[95:0], seed};
        end
    endtask

    task automatic chk32(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic chk1(input string n, input logic x, input logic g);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", n, x, g);
        end
    endtask

    // APB transfer; pready and the answer are taken at the rising edge that samples them
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            $display("[ERR] pready expected 1 seen %b", pready);
            end_sim();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic status(input logic [2:0] p, input logic [31:0] x, input logic [31:0] m);
        apb(1'b1, `TPLW_OFF_RDSEL, {29'h0, p});
        apb(1'b0, `TPLW_OFF_STATUS, 32'h0);
        chk32("status", x & m, q & m);
    endtask

    // Oldest line of a partition: first n lanes and sideband
    task automatic line(input logic [2:0] p, input logic [127:0] x, input int n,
                        input logic [31:0] s);
        apb(1'b1, `TPLW_OFF_RDSEL, {29'h0, p});
        for (int i = 0; i < n; i++) begin
            apb(1'b0, `TPLW_OFF_DATA0 + 8'(4 * i), 32'h0);
            chk32("data", x[32 * i +: 32], q);
        end
        apb(1'b0, `TPLW_OFF_SIDE, 32'h0);
        chk32("side", s, q);
    endtask

    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog far above the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, `TPLW_OFF_CTRL, 32'h0);
        chk32("ctrl", {20'h0, `TPLW_FILL_RST, 6'h0, `TPLW_MODE_RST}, q);
        chk1("part_full", 1'b0, part_full);
        apb(1'b0, 8'h40, 32'h0);
        chk1("pslverr", 1'b1, e);
        $display("test reset done");
        // Full line to 3, then straight on to 7 with a short end
        rnd128();
        d3 = d;
        for (int i = 0; i < 4; i++) begin
            u_tplw_fabric_model.wr(3'h3, {96'h0, d3[32 * i +: 32]}, 16'h000f, 8'h53, i == 0,
                                   1'b0, 1'b0);
        end
        rnd128();
        d7 = d;
        u_tplw_fabric_model.wr(3'h7, {96'h0, d7[31:0]}, 16'h000f, 8'h07, 1'b1, 1'b0, 1'b0);
        u_tplw_fabric_model.wr(3'h7, {96'h0, d7[63:32]}, 16'h000c, 8'h07, 1'b0, 1'b1, 1'b0);
        u_tplw_fabric_model.idle();
        status(3'h3, stat_exp(1, 5'h1, 2'h0), ALL_M);
        status(3'h7, stat_exp(1, 5'h1, 2'h0), ALL_M);
        line(3'h3, d3, 4, side_exp(16'hffff, 8'h53, 3'b001));
        line(3'h7, d7, 2, side_exp(16'h00cf, 8'h07, 3'b011));
        $display("test line32 done");
        // Partial lines of 4 and 3 built interleaved
        rnd128();
        d4 = d;
        u_tplw_fabric_model.wr(3'h4, {96'h0, d4[31:0]}, 16'h000f, 8'h44, 1'b1, 1'b0, 1'b0);
        u_tplw_fabric_model.idle();
        status(3'h4, stat_exp(0, 5'h0, 2'h1), ALL_M);
        rnd128();
        d3 = d;
        u_tplw_fabric_model.wr(3'h3, {96'h0, d3[31:0]}, 16'h000f, 8'h53, 1'b0, 1'b0, 1'b0);
        u_tplw_fabric_model.wr(3'h3, {96'h0, d3[63:32]}, 16'h000f, 8'h53, 1'b0, 1'b1, 1'b1);
        for (int i = 1; i < 4; i++) begin
            u_tplw_fabric_model.wr(3'h4, {96'h0, d4[32 * i +: 32]}, 16'h000f, 8'h44, 1'b0,
                                   1'b0, 1'b0);
        end
        u_tplw_fabric_model.idle();
        status(3'h4, stat_exp(1, 5'h1, 2'h0), ALL_M);
        status(3'h3, stat_exp(2, 5'h2, 2'h0), ALL_M);
        apb(1'b1, `TPLW_OFF_POP, 32'h3);
        line(3'h3, d3, 2, side_exp(16'h00ff, 8'h53, 3'b110));
        line(3'h4, d4, 4, side_exp(16'hffff, 8'h44, 3'b001));
        $display("test interleave done");
        // Empty mask and unstrobed cycles move nothing
        u_tplw_fabric_model.wr(3'h0, {128{1'b1}}, 16'h0000, 8'h11, 1'b1, 1'b1, 1'b0);
        repeat (4) u_tplw_fabric_model.idle();
        status(3'h0, stat_exp(0, 5'h0, 2'h0), ALL_M);
        u_tplw_fabric_model.term(3'h0, d[31:0], 8'h11);
        status(3'h0, stat_exp(1, 5'h1, 2'h0), ALL_M);
        line(3'h0, {96'h0, d[31:0]}, 1, side_exp(16'h000f, 8'h11, 3'b000));
        $display("test discard done");
        // Two writes per line in 64-bit mode
        apb(1'b1, `TPLW_OFF_CTRL, {20'h0, `TPLW_FILL_RST, 6'h0, `TPLW_MODE_64});
        rnd128();
        u_tplw_fabric_model.wr(3'h1, {64'h0, d[63:0]}, 16'h00ff, 8'h21, 1'b1, 1'b0, 1'b0);
        u_tplw_fabric_model.wr(3'h1, {64'h0, d[127:64]}, 16'h00fe, 8'h21, 1'b0, 1'b1, 1'b0);
        u_tplw_fabric_model.idle();
        status(3'h1, stat_exp(1, 5'h1, 2'h0), ALL_M);
        line(3'h1, d, 4, side_exp(16'hfeff, 8'h21, 3'b011));
        $display("test line64 done");
        // 128-bit lines fill partition 5 until it refuses
        apb(1'b1, `TPLW_OFF_CTRL, {20'h0, `TPLW_FILL_RST, 6'h0, `TPLW_MODE_128});
        for (occ = 0; occ < 17; occ++) begin
            rnd128();
            if (occ == 0) begin
                d5 = d;
            end
            u_tplw_fabric_model.wr(3'h5, d, 16'hffff, 8'h05, 1'b1, 1'b1, 1'b0);
            u_tplw_fabric_model.idle();
            @(negedge mclk);
            chk1("part_full", occ > `TPLW_FILL_RST, part_full);
        end
        status(3'h5, stat_exp(16, 5'h10, 2'h0), ALL_M);
        line(3'h5, d5, 4, side_exp(16'hffff, 8'h05, 3'b011));
        $display("test line128 done");
        end_sim();
    end
endmodule
